// >>> verif/test_tsn_top.sv
`timescale 1ns/1ps
`include "tsn_cfg.svh"
module test_tsn_top;
  logic pclk, presetn, psel, penable, pwrite, touch_in, slow, cur;
  logic [11:0] paddr, w;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, lamp_lit, notify_bit, write_req, write_ack;
  logic [15:0] img;
  logic [3:0] b;
  logic [64:0] exq[$];
  int unsigned writes;
  int num_errors = 0;
  int tests_run = 0;
  int n, k;

  tsn_top #(.DEBOUNCE_CYC(4), .FLASH_CYC(8)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .touch_in, .lamp_lit,
    .notify_bit, .write_req, .write_ack);
  tsn_host_model host (.pclk, .presetn, .slow, .write_req, .write_ack, .writes);

  // Bus clock, 40 ns period.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic cmp_rd(input logic [64:0] e, input logic [32:0] g);
    tests_run++;
    if (((g ^ e[32:0]) & {1'b1, e[64:33]}) !== 33'h0) begin
      num_errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e[32:0], g);
    end
  endtask : cmp_rd

  task automatic cmp_bit(input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_bit

  // One bus transfer; a read notes its expected answer and mask.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [64:0] e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) exq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic press(input logic v, input logic e);
    touch_in <= v;
    repeat (16) @(posedge pclk);
    cmp_bit(e, notify_bit);
  endtask : press

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // Compares every read answer with the oldest note.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) cmp_rd(exq.pop_front(), {pslverr, prdata});
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    test_done();
  end

  // Main sequence.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    touch_in = 1'b0;
    slow = 1'b0;
    k = $urandom(32'hAAFE509E);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `TSN_CTRL_OFS, 32'h0, {32'hFFFFFFFF, 33'h0});
    apb(1'b0, 12'h0FC, 32'h0, {32'hFFFFFFFF, 33'h1_0000_0000});
    for (k = 3; k < 5; k++) begin
      apb(1'b1, `TSN_NADDR_OFS, 32'(k) << 16, 65'h0);
      apb(1'b0, `TSN_STAT_OFS, 32'h0, {32'h10, 33'h10});
      apb(1'b1, `TSN_LADDR_OFS, 32'(k) << 16, 65'h0);
      apb(1'b0, `TSN_LADDR_OFS, 32'h0, {32'hFFFFF, 33'h0});
    end
    $display("test 1 done");
    w = 12'($urandom_range(199));
    b = 4'($urandom);
    apb(1'b1, `TSN_NADDR_OFS, {12'h0, 4'h1, w, b}, 65'h0);
    for (k = 0; k < 5; k++) begin
      apb(1'b1, `TSN_CTRL_OFS, {26'h0, 3'b100, 1'(k < 4), 2'(k == 4 ? 1 : k)}, 65'h0);
      repeat (2) begin
        n = writes;
        cur = (k % 4 == 0) ? 1'b1 : (k == 1) ? ~cur : (k == 2);
        press(1'b1, cur);
        cmp_bit(1'b1, writes == n + 1);
        apb(1'b0, `TSN_WRITE_OFS, 32'h0, {32'hFFFF, 33'(16'h1 << b)});
        apb(1'b0, `TSN_WADDR_OFS, 32'h0, {32'hFFFFF, 13'h0, 4'h0, w + 12'd1000, b});
        if (k % 4 == 0) cur = 1'b0;
        press(1'b0, cur);
      end
    end
    $display("test 2 done");
    slow <= 1'b1;
    img = 16'($urandom);
    apb(1'b1, `TSN_NADDR_OFS, {12'h0, 4'h2, w, b}, 65'h0);
    apb(1'b1, `TSN_IMAGE_OFS, {16'h0, img}, 65'h0);
    apb(1'b1, `TSN_CTRL_OFS, 32'h0D, 65'h0);
    apb(1'b1, `TSN_CTRL_OFS, 32'h2D, 65'h0);
    repeat (2) begin
      img[b] = ~img[b];
      press(1'b1, img[b]);
      apb(1'b0, `TSN_WORD_OFS, 32'h0, {32'hFFFF, 33'(img)});
      apb(1'b0, `TSN_WRITE_OFS, 32'h0, {32'hFFFF, 33'hFFFF});
      press(1'b0, img[b]);
    end
    apb(1'b1, `TSN_NADDR_OFS, {12'h0, 4'h2, w + 12'd1, b}, 65'h0);
    apb(1'b1, `TSN_CTRL_OFS, 32'h2C, 65'h0);
    press(1'b1, 1'b1);
    apb(1'b0, `TSN_WORD_OFS, 32'h0, {32'hFFFF, 33'(16'h1 << b)});
    apb(1'b1, `TSN_CTRL_OFS, 32'h0C, 65'h0);
    repeat (4) @(posedge pclk);
    cmp_bit(1'b0, notify_bit);
    apb(1'b0, `TSN_WORD_OFS, 32'h0, {32'hFFFF, 33'h0});
    press(1'b0, 1'b0);
    $display("test 3 done");
    apb(1'b1, `TSN_CTRL_OFS, 32'h24, 65'h0);
    apb(1'b1, `TSN_LAMP_OFS, 32'h1, 65'h0);
    press(1'b1, 1'b1);
    cmp_bit(1'b1, lamp_lit);
    apb(1'b1, `TSN_LAMP_OFS, 32'h0, 65'h0);
    repeat (3) @(posedge pclk);
    cmp_bit(1'b0, lamp_lit);
    cmp_bit(1'b1, notify_bit);
    press(1'b0, 1'b0);
    apb(1'b1, `TSN_CTRL_OFS, 32'h34, 65'h0);
    apb(1'b1, `TSN_LAMP_OFS, 32'h1, 65'h0);
    n = 0;
    repeat (40) begin
      cur = lamp_lit;
      @(posedge pclk);
      n += (lamp_lit !== cur);
    end
    cmp_bit(1'b1, n >= 4 && n <= 6);
    $display("test 4 done");
    test_done();
  end
endmodule : test_tsn_top

bind tsn_top tsn_top_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .lamp_lit, .notify_bit, .write_req, .write_ack);

// >>> verif/tsn_host_model.sv
`timescale 1ns/1ps
// Host side of the link: takes each pending write, promptly or slowly.
module tsn_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic write_req,
  output logic write_ack,
  output int unsigned writes
);
  int unsigned cnt;
  // Four-phase answer: ack rises after a pause and falls once req is gone.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_ack <= 1'b0;
      cnt <= 0;
      writes <= 0;
    end else if (write_req && !write_ack) begin
      cnt <= cnt + 1;
      if (cnt >= (slow ? 12 : 1)) begin
        write_ack <= 1'b1;
        cnt <= 0;
        writes <= writes + 1;
      end
    end else if (!write_req) begin
      write_ack <= 1'b0;
    end
  end
endmodule : tsn_host_model

// >>> verif/tsn_top_monitor.sv
`timescale 1ns/1ps
// Watches the bus answers and the link handshake of the switch block.
module tsn_top_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic lamp_lit,
  input wire logic notify_bit,
  input wire logic write_req,
  input wire logic write_ack
);
  // All checks share the bus clock and its reset.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("late ready");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("long ready");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("stray ready");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("stray error");
  a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error data");
  a_req_held: assert property (write_req && !write_ack |=> write_req)
    else $error("dropped request");
  a_req_released: assert property (write_req && write_ack |-> ##[1:5] !write_req)
    else $error("stuck request");
  a_reset_quiet: assert property ($rose(presetn) |->
    !pready && !lamp_lit && !notify_bit && !write_req)
    else $error("busy after reset");
endmodule : tsn_top_monitor

// >>> verilog/tsn_cfg.svh
`ifndef TSN_CFG_SVH
`define TSN_CFG_SVH
// ---------------------------------------------------------------
// Register byte offsets.
// ---------------------------------------------------------------
`define TSN_CTRL_OFS 12'h000
`define TSN_NADDR_OFS 12'h004
`define TSN_LADDR_OFS 12'h008
`define TSN_IMAGE_OFS 12'h00C
`define TSN_LAMP_OFS 12'h010
`define TSN_STAT_OFS 12'h014
`define TSN_WORD_OFS 12'h018
`define TSN_WADDR_OFS 12'h01C
`define TSN_WRITE_OFS 12'h020
// ---------------------------------------------------------------
// Control field positions.
// ---------------------------------------------------------------
`define TSN_CTRL_OP_LSB 0
`define TSN_CTRL_VER5_BIT 2
`define TSN_CTRL_WORDMODE_BIT 3
`define TSN_CTRL_FLASH_BIT 4
`define TSN_CTRL_SCREEN_BIT 5
`define TSN_CTRL_RESET 32'h0000_0000
// ---------------------------------------------------------------
// Address field layout: area code in 19:16, word in 15:4, bit in 3:0.
// ---------------------------------------------------------------
`define TSN_AREA_LSB 16
`define TSN_WORD_LSB 4
`define TSN_AREA_CORE_IO 4'h0
`define TSN_AREA_LINK_RELAY 4'h1
`define TSN_AREA_DATA_MEMORY 4'h2
`define TSN_AREA_PRESENT_VALUE 4'h3
`define TSN_AREA_DONE_FLAG 4'h4
// Last link-relay word that is moved, 199, and the core I/O word that link-relay word 0 lands on, 1000.
`define TSN_LINK_RELAY_LAST 12'h0C7
`define TSN_LINK_RELAY_BASE 12'h3E8
// ---------------------------------------------------------------
// Timing: debounce 10 ms, flash half period 250 ms at 25 MHz.
// ---------------------------------------------------------------
`define TSN_CLK_HZ 25000000
`define TSN_DEBOUNCE_MS 10
`define TSN_FLASH_MS 250
`define TSN_DEBOUNCE_CYC ((`TSN_CLK_HZ / 1000) * `TSN_DEBOUNCE_MS)
`define TSN_FLASH_CYC ((`TSN_CLK_HZ / 1000) * `TSN_FLASH_MS)
`endif

// >>> verilog/tsn_debounce.sv
`timescale 1ns/1ps
`include "tsn_cfg.svh"
// Synchronises a raw switch level and accepts a change only after it holds.
module tsn_debounce #(
  parameter int unsigned HOLD_CYC = 250000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic raw_in,
  output logic level_out
);
  logic sync1_r;
  logic sync2_r;
  logic [31:0] cnt_r;
  wire differs = (sync2_r != level_out);
  wire done = (cnt_r >= HOLD_CYC - 1);

  // Two-stage synchroniser, then a hold counter restarted on any bounce.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      cnt_r <= 32'h0000_0000;
      level_out <= 1'b0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      if (!differs) begin
        cnt_r <= 32'h0000_0000;
      end else if (done) begin
        cnt_r <= 32'h0000_0000;
        level_out <= sync2_r;
      end else begin
        cnt_r <= cnt_r + 32'h0000_0001;
      end
    end
  end
endmodule : tsn_debounce

// >>> verilog/tsn_flash.sv
`timescale 1ns/1ps
`include "tsn_cfg.svh"
// Free-running flash phase for a flashing lamp.
module tsn_flash #(
  parameter int unsigned HALF_CYC = 6250000
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic phase_out
);
  logic [31:0] cnt_r;
  wire wrap = (cnt_r >= HALF_CYC - 1);

  // Toggles the phase once every half period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 32'h0000_0000;
      phase_out <= 1'b0;
    end else if (wrap) begin
      cnt_r <= 32'h0000_0000;
      phase_out <= ~phase_out;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end
endmodule : tsn_flash

// >>> verilog/tsn_pkg.sv
package tsn_pkg;
  // Notification operation types.
  typedef enum logic [1:0] {
    TSN_OP_MOMENTARY = 2'h0,
    TSN_OP_ALTERNATE = 2'h1,
    TSN_OP_SET = 2'h2,
    TSN_OP_RESET = 2'h3
  } tsn_op_t;
  // Write-back sequencer states.
  typedef enum logic [2:0] {
    TSN_ST_IDLE = 3'b001,
    TSN_ST_POST = 3'b010,
    TSN_ST_WAIT = 3'b100
  } tsn_state_t;
endpackage : tsn_pkg

// >>> verilog/tsn_top.sv
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "tsn_cfg.svh"
module tsn_top #(
  parameter int unsigned DEBOUNCE_CYC = `TSN_DEBOUNCE_CYC,
  parameter int unsigned FLASH_CYC = `TSN_FLASH_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic touch_in,
  output logic lamp_lit,
  output logic notify_bit,
  output logic write_req,
  input wire logic write_ack
);
  import tsn_pkg::*;

  // ---------------------------------------------------------------
  // Registers.
  // ---------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [19:0] naddr_r;
  logic [19:0] laddr_r;
  logic [15:0] image_r;
  logic lamp_r;
  logic [15:0] word_r;
  logic [19:0] waddr_r;
  logic [15:0] wmask_r;
  logic reject_r;
  logic pressed_r;
  logic notify_r;
  logic pend_r;
  logic screen_r;
  logic ack_sync1_r;
  logic ack_sync2_r;
  tsn_state_t state_r;
  tsn_state_t state_nxt;
  logic [31:0] rdata_nxt;

  // ---------------------------------------------------------------
  // Switch conditioning and flash timing.
  // ---------------------------------------------------------------
  logic pressed;
  logic flash_phase;
  tsn_debounce #(.HOLD_CYC(DEBOUNCE_CYC)) u_deb (
    .pclk(pclk),
    .presetn(presetn),
    .raw_in(touch_in),
    .level_out(pressed)
  );
  tsn_flash #(.HALF_CYC(FLASH_CYC)) u_flash (
    .pclk(pclk),
    .presetn(presetn),
    .phase_out(flash_phase)
  );

  // ---------------------------------------------------------------
  // Bus decode.
  // ---------------------------------------------------------------
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire hit_ctrl = (paddr == `TSN_CTRL_OFS);
  wire hit_naddr = (paddr == `TSN_NADDR_OFS);
  wire hit_laddr = (paddr == `TSN_LADDR_OFS);
  wire hit_image = (paddr == `TSN_IMAGE_OFS);
  wire hit_lamp = (paddr == `TSN_LAMP_OFS);
  wire hit_stat = (paddr == `TSN_STAT_OFS);
  wire hit_word = (paddr == `TSN_WORD_OFS);
  wire hit_waddr = (paddr == `TSN_WADDR_OFS);
  wire hit_write = (paddr == `TSN_WRITE_OFS);
  wire hit_any = hit_ctrl | hit_naddr | hit_laddr | hit_image | hit_lamp | hit_stat |
                 hit_word | hit_waddr | hit_write;
  wire [31:0] stat_val = {26'h0, state_r != TSN_ST_IDLE, reject_r, lamp_lit,
                          pressed_r, notify_r, pend_r};

  // ---------------------------------------------------------------
  // Configuration fields.
  // ---------------------------------------------------------------
  wire ver5 = ctrl_r[`TSN_CTRL_VER5_BIT];
  wire word_mode = ctrl_r[`TSN_CTRL_WORDMODE_BIT];
  wire flash_attr = ctrl_r[`TSN_CTRL_FLASH_BIT];
  wire screen_on = ctrl_r[`TSN_CTRL_SCREEN_BIT];
  wire [1:0] op_raw = ctrl_r[`TSN_CTRL_OP_LSB +: 2];
  wire [1:0] op_sel = ver5 ? op_raw : 2'(TSN_OP_MOMENTARY);
  wire momentary = (op_sel == 2'(TSN_OP_MOMENTARY));

  // ---------------------------------------------------------------
  // Address split into area, word number and bit index.
  // ---------------------------------------------------------------
  wire [3:0] n_area = naddr_r[`TSN_AREA_LSB +: 4];
  wire [11:0] n_word = naddr_r[`TSN_WORD_LSB +: 12];
  wire [3:0] n_bit = naddr_r[3:0];
  wire [3:0] w_area = pwdata[`TSN_AREA_LSB +: 4];
  wire [3:0] l_area = pwdata[`TSN_AREA_LSB +: 4];
  wire area_bad = (w_area == `TSN_AREA_PRESENT_VALUE) || (w_area == `TSN_AREA_DONE_FLAG) ||
                  (w_area > `TSN_AREA_DONE_FLAG);
  wire larea_bad = (l_area == `TSN_AREA_PRESENT_VALUE) || (l_area == `TSN_AREA_DONE_FLAG) ||
                   (l_area > `TSN_AREA_DONE_FLAG);
  wire is_link_relay = (n_area == `TSN_AREA_LINK_RELAY) && (n_word <= `TSN_LINK_RELAY_LAST);
  wire [19:0] out_addr = is_link_relay ?
                         {`TSN_AREA_CORE_IO, n_word + `TSN_LINK_RELAY_BASE, n_bit}
                         : naddr_r;
  wire [15:0] bit_one = 16'h0001 << n_bit;

  // ---------------------------------------------------------------
  // Press events and screen change.
  // ---------------------------------------------------------------
  wire press = pressed && !pressed_r;
  wire release_ev = !pressed && pressed_r;
  wire screen_drop = screen_r && !screen_on && momentary && notify_r;
  wire [15:0] base_word = image_r & ~bit_one;
  // In word mode the latching types start from the bit as the display image holds it.
  wire cur_bit = (word_mode && !momentary) ? image_r[n_bit] : notify_r;
  logic notify_nxt;
  assign notify_nxt = screen_drop ? 1'b0 :
                      !screen_on ? notify_r :
                      momentary ? (press ? 1'b1 : (release_ev ? 1'b0 : notify_r)) :
                      !press ? notify_r :
                      (op_sel == 2'(TSN_OP_ALTERNATE)) ? ~cur_bit :
                      (op_sel == 2'(TSN_OP_SET)) ? 1'b1 :
                      1'b0;
  // Every accepted press while the screen is on is reported, even when the bit already has its new value.
  wire update = (notify_nxt != notify_r) || (screen_on && press) ||
                screen_drop;
  // Word mode: momentary drives others to zero, others use the display image.
  wire [15:0] word_nxt = momentary ? (notify_nxt ? bit_one : 16'h0000)
                                   : (base_word | (notify_nxt ? bit_one : 16'h0000));
  wire [15:0] mask_nxt = word_mode ? 16'hFFFF : bit_one;
  wire ack_seen = ack_sync2_r;

  // ---------------------------------------------------------------
  // Write-back sequencer.
  // ---------------------------------------------------------------
  // Four-phase handshake: post, wait for the ack, then wait for it to fall.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      TSN_ST_IDLE: if (pend_r) state_nxt = TSN_ST_POST;
      TSN_ST_POST: if (ack_seen) state_nxt = TSN_ST_WAIT;
      TSN_ST_WAIT: if (!ack_seen) state_nxt = TSN_ST_IDLE;
      default: state_nxt = TSN_ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Read data selection.
  // ---------------------------------------------------------------
  // The address hits are exclusive, so the selected fields are simply or-ed together.
  assign rdata_nxt = ({32{hit_ctrl}} & ctrl_r) |
                     ({32{hit_naddr}} & {12'h000, naddr_r}) |
                     ({32{hit_laddr}} & {12'h000, laddr_r}) |
                     ({32{hit_image}} & {16'h0000, image_r}) |
                     ({32{hit_lamp}} & {31'h0000_0000, lamp_r}) |
                     ({32{hit_stat}} & stat_val) |
                     ({32{hit_word}} & {16'h0000, word_r}) |
                     ({32{hit_waddr}} & {12'h000, waddr_r}) |
                     ({32{hit_write}} & {16'h0000, wmask_r});

  // ---------------------------------------------------------------
  // Bus response.
  // ---------------------------------------------------------------
  // Zero wait states; an unmapped address answers with an error and zero data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      prdata <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Software-written configuration.
  // ---------------------------------------------------------------
  // A write lands only at the access edge, where pready is high.
  wire wr_ok = wr && pready;
  wire wr_ctrl = wr_ok && hit_ctrl;
  wire wr_naddr = wr_ok && hit_naddr;
  wire wr_laddr = wr_ok && hit_laddr;
  wire wr_image = wr_ok && hit_image;
  wire wr_lamp = wr_ok && hit_lamp;

  // Control word and the lamp bit written by the host.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `TSN_CTRL_RESET;
      lamp_r <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_r <= {26'h0, pwdata[5:0]};
      if (wr_lamp) lamp_r <= pwdata[0];
    end
  end

  // Allocation addresses; a forbidden area keeps the old address and raises reject.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      naddr_r <= 20'h00000;
      laddr_r <= 20'h00000;
      reject_r <= 1'b0;
    end else begin
      if (wr_naddr && !area_bad) naddr_r <= pwdata[19:0];
      if (wr_laddr && !larea_bad) laddr_r <= pwdata[19:0];
      if (wr_naddr) reject_r <= area_bad;
      if (wr_laddr) reject_r <= larea_bad;
    end
  end

  // Display image loaded by software when the screen is shown, edited by latching-type notifications in word mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      image_r <= 16'h0000;
    end else if (wr_image) begin
      image_r <= pwdata[15:0];
    end else if (update && word_mode && !momentary) begin
      image_r <= word_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Notify state and pending write-back.
  // ---------------------------------------------------------------
  // Previous switch and screen levels for edge detection, and the notify bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pressed_r <= 1'b0;
      screen_r <= 1'b0;
      notify_r <= 1'b0;
    end else begin
      pressed_r <= pressed;
      screen_r <= screen_on;
      notify_r <= notify_nxt;
    end
  end

  // Pending flag; a new update wins over the sequencer taking the old one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 1'b0;
    end else if (update) begin
      pend_r <= 1'b1;
    end else if (state_r == TSN_ST_IDLE && pend_r) begin
      pend_r <= 1'b0;
    end
  end

  // Word, address and mask offered to the host; a newer update replaces them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_r <= 16'h0000;
      waddr_r <= 20'h00000;
      wmask_r <= 16'h0000;
    end else if (update) begin
      word_r <= word_mode ? word_nxt : (notify_nxt ? bit_one : 16'h0000);
      waddr_r <= out_addr;
      wmask_r <= mask_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Link handshake and registered outputs.
  // ---------------------------------------------------------------
  // The acknowledge comes from the link side, so it passes two flops first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_sync1_r <= 1'b0;
      ack_sync2_r <= 1'b0;
    end else begin
      ack_sync1_r <= write_ack;
      ack_sync2_r <= ack_sync1_r;
    end
  end

  // Sequencer state and the block outputs, each straight from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= TSN_ST_IDLE;
      write_req <= 1'b0;
      lamp_lit <= 1'b0;
      notify_bit <= 1'b0;
    end else begin
      state_r <= state_nxt;
      write_req <= (state_nxt == TSN_ST_POST);
      lamp_lit <= lamp_r && (!flash_attr || flash_phase);
      notify_bit <= notify_nxt;
    end
  end
endmodule : tsn_top
